// ### cbx_defines.vh
// Purpose: constants of the port pin crossbar
// Assumes: register byte address is four times the register index
// Notes: signal and pin numbers index the crossbar's own vectors
`ifndef CBX_DEFINES_VH
`define CBX_DEFINES_VH

// register indices, byte address = index * 4
`define CBX_IDX_ROUTE0 8'hE1
`define CBX_IDX_ROUTE2 8'hC7
`define CBX_IDX_IN_MODE 8'h10
`define CBX_IDX_OUT_MODE 8'h11
`define CBX_IDX_SKIP 8'h12
`define CBX_IDX_LATCH 8'h13
`define CBX_IDX_PIN_STATE 8'h14

// reset values
`define CBX_RST_ROUTE0 8'h00
`define CBX_RST_ROUTE2 8'h00
`define CBX_RST_IN_MODE 8'hFF
`define CBX_RST_OUT_MODE 8'h00
`define CBX_RST_SKIP 8'h00
`define CBX_RST_LATCH 8'hFF

// route select 0 fields
`define CBX_R0_UART 0
`define CBX_R0_CAN 1
`define CBX_R0_SPI 2
`define CBX_R0_SMBUS 3
`define CBX_R0_CMP0 4
`define CBX_R0_CMP0A 5
`define CBX_R0_CMP1 6
`define CBX_R0_CMP1A 7

// route select 2 fields
`define CBX_R2_ENABLE 6
`define CBX_R2_PULLUP_OFF 7

// peripheral signal numbers, flexible ones in priority order from 4
`define CBX_SIG_UART_TX 4'h0
`define CBX_SIG_UART_RX 4'h1
`define CBX_SIG_CAN_TX 4'h2
`define CBX_SIG_CAN_RX 4'h3
`define CBX_SIG_SCK 4'h4
`define CBX_SIG_MISO 4'h5
`define CBX_SIG_MOSI 4'h6
`define CBX_SIG_NSS 4'h7
`define CBX_SIG_SDA 4'h8
`define CBX_SIG_SCL 4'h9
`define CBX_SIG_CMP0 4'hA
`define CBX_SIG_CMP0A 4'hB
`define CBX_SIG_CMP1 4'hC
`define CBX_SIG_CMP1A 4'hD
`define CBX_NSIG 14
`define CBX_FIRST_FLEX 4

// fixed pins
`define CBX_PIN_UART_TX 4
`define CBX_PIN_UART_RX 5
`define CBX_PIN_CAN_TX 6
`define CBX_PIN_CAN_RX 7

// bus answers
`define CBX_RESP_OKAY 2'h0
`define CBX_RESP_SLVERR 2'h2

`endif

// ### cbx_port_crossbar.v
// Purpose: priority crossbar placing peripheral signals on port pins
// Assumes: pin inputs synchronous to clk, AXI4-Lite register access
// Notes: pin and peripheral outputs are registered, one cycle behind config
//
// Contract
// RQ1 - enabling the two-wire bus routes its data and clock pins together
// RQ2 - enabling uart or can routes transmit and receive together
// RQ3 - uart transmit sits on pin 4, receive on pin 5
// RQ4 - can transmit sits on pin 6, receive on pin 7
// RQ5 - leftover unskipped pins become general purpose port pins
// RQ6 - spi slave select takes a pin only in four-wire mode
// RQ7 - software sets input, output modes, skips, routes, then enable last
// RQ8 - analog pins lose pullup, output driver and input receiver
// RQ9 - input mode bit 1 means digital, 0 means analog
// RQ10 - after reset every pin is a digital input
// RQ11 - output mode bit picks open-drain or push-pull, also for peripherals
// RQ12 - two-wire bus pins are always open-drain
// RQ13 - pullup disable 0 gives open-drain pins a weak pullup
// RQ14 - weak pullup is off while the pin drives 0
// RQ15 - writing 1 to crossbar enable activates the routing
// RQ16 - while disabled, pins stay plain inputs whatever the routes say
// RQ17 - while disabled, all output drivers are off
// RQ18 - software should skip every analog input pin
// RQ19 - analog use of digital-mode pins is discouraged
// RQ20 - route select 0 holds the eight peripheral enables, bit 7 to 0
// RQ21 - enabled spi takes three or four pins by wire mode
// RQ22 - route select 2 has pullup disable at 7, enable at 6, resets 0
// RQ23 - enabled signals take the next free unskipped unfixed pins by priority
//
// Chosen here: the AXI4-Lite slave port.
`include "cbx_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module cbx_port_crossbar #(
	parameter NPINS = 8,
	parameter AW = 12
)(
	input wire clk,
	input wire arst_n,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] spi_slave_select_mode,
	input wire [`CBX_NSIG-1:0] periph_out,
	input wire [`CBX_NSIG-1:0] periph_oe,
	output reg [`CBX_NSIG-1:0] periph_in,
	input wire [NPINS-1:0] pin_in,
	output reg [NPINS-1:0] pin_out,
	output reg [NPINS-1:0] pin_oe,
	output reg [NPINS-1:0] pin_pullup_en,
	output reg [NPINS-1:0] pin_receiver_en
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] peripheral_route_select0;
reg [7:0] peripheral_route_select2;
reg [NPINS-1:0] pin_input_mode;
reg [NPINS-1:0] pin_output_mode;
reg [NPINS-1:0] pin_skip_select;
reg [NPINS-1:0] pin_latch;

wire crossbar_enable;
wire weak_pullup_disable;
assign crossbar_enable = peripheral_route_select2[`CBX_R2_ENABLE];
assign weak_pullup_disable = peripheral_route_select2[`CBX_R2_PULLUP_OFF];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg aw_got;
reg w_got;
reg [AW-1:0] aw_addr;
reg [7:0] w_byte;
wire [AW-1:0] wr_addr_now;
wire [7:0] wr_data_now;
wire [7:0] wr_idx;
wire [7:0] rd_idx;
wire aw_take;
wire w_take;
wire wr_fire;
wire wr_hit;
reg rd_hit;
reg [7:0] rd_val;

assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
assign s_axi_wready = ~w_got & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign aw_take = s_axi_awvalid & s_axi_awready;
assign w_take = s_axi_wvalid & s_axi_wready;
assign wr_fire = (aw_got | aw_take) & (w_got | w_take) & ~s_axi_bvalid;
assign wr_addr_now = aw_got ? aw_addr : s_axi_awaddr;
assign wr_data_now = w_got ? w_byte : s_axi_wdata[7:0];
assign wr_idx = wr_addr_now[9:2];
assign rd_idx = s_axi_araddr[9:2];
assign wr_hit = (wr_addr_now[AW-1:10] == 0) && (wr_addr_now[1:0] == 2'h0) &&
	((wr_idx == `CBX_IDX_ROUTE0) || (wr_idx == `CBX_IDX_ROUTE2) ||
	(wr_idx == `CBX_IDX_IN_MODE) || (wr_idx == `CBX_IDX_OUT_MODE) ||
	(wr_idx == `CBX_IDX_SKIP) || (wr_idx == `CBX_IDX_LATCH));

// strobe only matters on the low lane
reg w_lane0;
wire lane0_now;
assign lane0_now = w_got ? w_lane0 : s_axi_wstrb[0];

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		aw_got <= 1'b0;
		w_got <= 1'b0;
		aw_addr <= {AW{1'b0}};
		w_byte <= 8'h00;
		w_lane0 <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CBX_RESP_OKAY;
	end
	else
	begin
		if (wr_fire)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `CBX_RESP_OKAY : `CBX_RESP_SLVERR;
		end
		else
		begin
			if (aw_take)
			begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_got <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		peripheral_route_select0 <= `CBX_RST_ROUTE0;
		peripheral_route_select2 <= `CBX_RST_ROUTE2; // RQ22
		pin_input_mode <= `CBX_RST_IN_MODE; // RQ10
		pin_output_mode <= `CBX_RST_OUT_MODE;
		pin_skip_select <= `CBX_RST_SKIP;
		pin_latch <= `CBX_RST_LATCH;
	end
	else if (wr_fire && wr_hit && lane0_now)
	begin
		case (wr_idx)
			`CBX_IDX_ROUTE0: peripheral_route_select0 <= wr_data_now; // RQ20
			`CBX_IDX_ROUTE2:
			begin
				// only enable and pullup disable are kept
				peripheral_route_select2 <= wr_data_now & 8'hC0; // RQ22
			end
			`CBX_IDX_IN_MODE: pin_input_mode <= wr_data_now[NPINS-1:0];
			`CBX_IDX_OUT_MODE: pin_output_mode <= wr_data_now[NPINS-1:0];
			`CBX_IDX_SKIP: pin_skip_select <= wr_data_now[NPINS-1:0];
			`CBX_IDX_LATCH: pin_latch <= wr_data_now[NPINS-1:0];
			default: pin_latch <= pin_latch;
		endcase
	end
end

always @*
begin
	rd_hit = (s_axi_araddr[AW-1:10] == 0) && (s_axi_araddr[1:0] == 2'h0);
	rd_val = 8'h00;
	case (rd_idx)
		`CBX_IDX_ROUTE0: rd_val = peripheral_route_select0;
		`CBX_IDX_ROUTE2: rd_val = peripheral_route_select2;
		`CBX_IDX_IN_MODE: rd_val = pin_input_mode;
		`CBX_IDX_OUT_MODE: rd_val = pin_output_mode;
		`CBX_IDX_SKIP: rd_val = pin_skip_select;
		`CBX_IDX_LATCH: rd_val = pin_latch;
		`CBX_IDX_PIN_STATE: rd_val = pin_in & pin_input_mode; // RQ8
		default: rd_hit = 1'b0;
	endcase
end

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `CBX_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= {24'h000000, rd_hit ? rd_val : 8'h00};
		s_axi_rresp <= rd_hit ? `CBX_RESP_OKAY : `CBX_RESP_SLVERR;
	end
	else if (s_axi_rvalid && s_axi_rready)
	begin
		s_axi_rvalid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// priority decode

reg [`CBX_NSIG-1:0] req;
reg [`CBX_NSIG-1:0] used;
reg [NPINS-1:0] fixed_pin;
reg [NPINS-1:0] routed;
reg [3:0] sel [0:NPINS-1];
reg got;
integer i;
integer j;

always @*
begin
	req = {`CBX_NSIG{1'b0}};
	// both ends of each paired peripheral follow one enable
	req[`CBX_SIG_UART_TX] = peripheral_route_select0[`CBX_R0_UART]; // RQ2
	req[`CBX_SIG_UART_RX] = peripheral_route_select0[`CBX_R0_UART]; // RQ2
	req[`CBX_SIG_CAN_TX] = peripheral_route_select0[`CBX_R0_CAN]; // RQ2
	req[`CBX_SIG_CAN_RX] = peripheral_route_select0[`CBX_R0_CAN]; // RQ2
	req[`CBX_SIG_SCK] = peripheral_route_select0[`CBX_R0_SPI]; // RQ21
	req[`CBX_SIG_MISO] = peripheral_route_select0[`CBX_R0_SPI]; // RQ21
	req[`CBX_SIG_MOSI] = peripheral_route_select0[`CBX_R0_SPI]; // RQ21
	req[`CBX_SIG_NSS] = peripheral_route_select0[`CBX_R0_SPI] &
		(spi_slave_select_mode != 2'h0); // RQ6
	req[`CBX_SIG_SDA] = peripheral_route_select0[`CBX_R0_SMBUS]; // RQ1
	req[`CBX_SIG_SCL] = peripheral_route_select0[`CBX_R0_SMBUS]; // RQ1
	req[`CBX_SIG_CMP0] = peripheral_route_select0[`CBX_R0_CMP0];
	req[`CBX_SIG_CMP0A] = peripheral_route_select0[`CBX_R0_CMP0A];
	req[`CBX_SIG_CMP1] = peripheral_route_select0[`CBX_R0_CMP1];
	req[`CBX_SIG_CMP1A] = peripheral_route_select0[`CBX_R0_CMP1A];

	fixed_pin = {NPINS{1'b0}};
	routed = {NPINS{1'b0}};
	used = {`CBX_NSIG{1'b0}};
	for (i = 0; i < NPINS; i = i + 1)
		sel[i] = 4'h0;

	// fixed pins override skip selection
	if (req[`CBX_SIG_UART_TX])
	begin
		fixed_pin[`CBX_PIN_UART_TX] = 1'b1; // RQ3
		fixed_pin[`CBX_PIN_UART_RX] = 1'b1; // RQ3
		sel[`CBX_PIN_UART_TX] = `CBX_SIG_UART_TX; // RQ3
		sel[`CBX_PIN_UART_RX] = `CBX_SIG_UART_RX; // RQ3
	end
	if (req[`CBX_SIG_CAN_TX])
	begin
		fixed_pin[`CBX_PIN_CAN_TX] = 1'b1; // RQ4
		fixed_pin[`CBX_PIN_CAN_RX] = 1'b1; // RQ4
		sel[`CBX_PIN_CAN_TX] = `CBX_SIG_CAN_TX; // RQ4
		sel[`CBX_PIN_CAN_RX] = `CBX_SIG_CAN_RX; // RQ4
	end
	routed = fixed_pin;

	// each free pin takes the highest-priority signal still unplaced
	for (i = 0; i < NPINS; i = i + 1)
	begin
		got = 1'b0;
		if (!pin_skip_select[i] && !fixed_pin[i])
		begin
			for (j = `CBX_FIRST_FLEX; j < `CBX_NSIG; j = j + 1)
			begin
				if (req[j] && !used[j] && !got)
				begin
					got = 1'b1;
					used[j] = 1'b1;
					sel[i] = j[3:0]; // RQ23
				end
			end
		end
		routed[i] = fixed_pin[i] | got; // RQ23
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-pin drivers

genvar g;
generate
	for (g = 0; g < NPINS; g = g + 1)
	begin : pin_slice
		wire two_wire;
		wire open_drain;
		wire value;
		wire want_drive;
		wire active;
		wire next_oe;
		wire next_out;
		wire next_pullup;
		assign two_wire = routed[g] &&
			((sel[g] == `CBX_SIG_SDA) || (sel[g] == `CBX_SIG_SCL));
		assign open_drain = ~pin_output_mode[g] | two_wire; // RQ11 RQ12
		// unrouted pins fall back to the port latch
		assign value = routed[g] ? periph_out[sel[g]] : pin_latch[g]; // RQ5
		assign want_drive = routed[g] ? periph_oe[sel[g]] : 1'b1; // RQ5
		assign active = crossbar_enable & pin_input_mode[g]; // RQ15 RQ16 RQ9
		assign next_oe = active & want_drive &
			(open_drain ? ~value : 1'b1); // RQ17 RQ8
		assign next_out = open_drain ? 1'b0 : value;
		assign next_pullup = pin_input_mode[g] & ~weak_pullup_disable &
			open_drain & ~(next_oe & ~next_out); // RQ13 RQ14 RQ8

		always @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				pin_out[g] <= 1'b0;
				pin_oe[g] <= 1'b0; // RQ10
				pin_pullup_en[g] <= 1'b0;
				pin_receiver_en[g] <= 1'b1;
			end
			else
			begin
				pin_out[g] <= next_out;
				pin_oe[g] <= next_oe;
				pin_pullup_en[g] <= next_pullup;
				pin_receiver_en[g] <= pin_input_mode[g]; // RQ8 RQ9
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// pin to peripheral inputs

reg [`CBX_NSIG-1:0] next_periph_in;
integer k;

always @*
begin
	next_periph_in = {`CBX_NSIG{1'b0}};
	for (k = 0; k < NPINS; k = k + 1)
	begin
		if (crossbar_enable && routed[k] && pin_input_mode[k]) // RQ16
			next_periph_in[sel[k]] = pin_in[k];
	end
end

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
		periph_in <= {`CBX_NSIG{1'b0}};
	else
		periph_in <= next_periph_in;
end

endmodule

`default_nettype wire

// ### cbx_board_model.sv
// Purpose: board side of the port pins
// Assumes: bench drives ext_en and ext_val after clock edges
// Notes: an undriven pin without pullup toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module cbx_board_model (
	input wire logic clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	logic [7:0] flt = 8'h55;
	always @(posedge clk)
		flt <= ~flt;
	// device first, then board driver, then pullup, else floating
	assign pin_in = (pin_oe & pin_out) |
		(~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pullup_en | flt))));
endmodule
`default_nettype wire

// ### cbx_port_crossbar_asserts.sv
// Purpose: port checks of the crossbar
// Assumes: write address and data are taken in one cycle
// Notes: enable and route select 0 are tracked from bus writes
`include "cbx_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cbx_port_crossbar_asserts #(
	parameter NPINS = 8,
	parameter AW = 12
)(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [`CBX_NSIG-1:0] periph_oe,
	input wire logic [`CBX_NSIG-1:0] periph_in,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe,
	input wire logic [NPINS-1:0] pin_pullup_en,
	input wire logic [NPINS-1:0] pin_receiver_en
);
	logic en;
	logic [7:0] r0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en <= 1'b0;
			r0 <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0])
		begin
			if (s_axi_awaddr == 12'h31C)
				en <= s_axi_wdata[`CBX_R2_ENABLE];
			if (s_axi_awaddr == 12'h384)
				r0 <= s_axi_wdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////
	property p_off_drv;
		!en |=> pin_oe == '0;
	endproperty
	a_off_drv: assert property (p_off_drv) else $error("driver on while off");
	property p_off_in;
		!en |=> periph_in == '0;
	endproperty
	a_off_in: assert property (p_off_in) else $error("input routed while off");
	property p_uart;
		en && r0[0] |=> (!pin_oe[4] || $past(periph_oe[0]))
			&& (!pin_receiver_en[5] || periph_in[1] == $past(pin_in[5]));
	endproperty
	a_uart: assert property (p_uart) else $error("uart pins wrong");
	property p_can;
		en && r0[1] |=> (!pin_oe[6] || $past(periph_oe[2]))
			&& (!pin_receiver_en[7] || periph_in[3] == $past(pin_in[7]));
	endproperty
	a_can: assert property (p_can) else $error("can pins wrong");
	property p_analog;
		(~pin_receiver_en & (pin_oe | pin_pullup_en)) == '0;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin active");
	property p_pull0;
		(pin_oe & ~pin_out & pin_pullup_en) == '0;
	endproperty
	a_pull0: assert property (p_pull0) else $error("pullup while low");
	property p_rst;
		!$past(arst_n) |-> pin_receiver_en == '1 && pin_oe == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("pins not inputs");
	property p_rst_pull;
		!$past(arst_n) |=> pin_pullup_en == '1;
	endproperty
	a_rst_pull: assert property (p_rst_pull) else $error("pullups off");
endmodule
bind cbx_port_crossbar cbx_port_crossbar_asserts #(.NPINS(NPINS), .AW(AW)) chk_i (.*);
`default_nettype wire

// ### cbx_port_crossbar_tb.sv
// Purpose: self-checking bench of the crossbar
// Assumes: board model on the pins
// Notes: placement expected from a bench function
`include "cbx_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cbx_port_crossbar_tb;
	logic clk = 0;
	logic arst_n = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [1:0] spi_slave_select_mode = '0;
	logic [13:0] periph_out = '0, periph_oe = '0;
	wire [13:0] periph_in;
	wire [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_receiver_en;
	logic [7:0] ext_en = '0, ext_val = '0;
	logic [31:0] seed = 32'h00002920;
	int miscompares = 0, checks_done = 0, cyc = 0;
	logic [1:0] wb;
	logic [11:0] ra[6] = '{12'h384, 12'h31C, 12'h040, 12'h044, 12'h048, 12'h7FC};
	logic [7:0] rx[6] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0] cr[4] = '{8'h04, 8'h04, 8'h08, 8'hF3};
	logic [7:0] cs[4] = '{8'h02, 8'h02, 8'h01, 8'h00};
	cbx_port_crossbar cbx_port_crossbar_i (.*);
	cbx_board_model cbx_board_model_i (.*);
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// pin p holds the signal number in nibble p, F for port pin
	function automatic [31:0] place(input [7:0] r0, input [7:0] sk, input bit four);
		int p = 0;
		bit on;
		place = '1;
		if (r0[0])
			place[23:16] = 8'h10;
		if (r0[1])
			place[31:24] = 8'h32;
		for (int s = 4; s < 14; s++)
		begin
			on = s < 8 ? r0[2] && (s != 7 || four) : s < 10 ? r0[3] : r0[s - 6];
			while (on && p < 8 && (sk[p] || place[p*4+:4] != 4'hF))
				p++;
			if (on && p < 8)
			begin
				place[p*4+:4] = s[3:0];
				p++;
			end
		end
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
		bit ta, tw;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw))
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			ta |= s_axi_awready;
			tw |= s_axi_wready;
		end
		while (!s_axi_bvalid)
			@(posedge clk);
		wb = s_axi_bresp;
		s_axi_bready <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] d, e, pl;
		logic [1:0] r;
		logic [7:0] eoe, eout, r0, sk;
		logic [13:0] ein, po, pout;
		logic [3:0] s;
		bit four;
		repeat (10) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		chk("pin_oe", 0, pin_oe);
		chk("receiver", 8'hFF, pin_receiver_en);
		for (int i = 0; i < 6; i++)
		begin
			rd(ra[i], d, r);
			chk("rdata", rx[i], d);
			chk("rresp", i == 5 ? 2 : 0, r);
		end
		wr(12'h7FC, 0);
		chk("bresp", 2, wb);
		$display("test reset done");
		d = xs();
		wr(12'h384, 32'h000000FF);
		chk("bresp", 0, wb);
		periph_oe <= '1;
		periph_out <= d[13:0];
		ext_en <= '1;
		ext_val <= d[21:14];
		repeat (3) @(posedge clk);
		chk("pin_oe", 0, pin_oe);
		chk("periph_in", 0, periph_in);
		$display("test disabled done");
		wr(12'h040, 32'hFF);
		wr(12'h044, 32'hFF);
		wr(12'h048, 0);
		wr(12'h384, 0);
		wr(12'h31C, 32'h40);
		for (int i = 0; i < 24; i++)
		begin
			d = xs();
			e = xs();
			r0 = i < 4 ? cr[i] : d[7:0];
			sk = i < 4 ? cs[i] : d[15:8] & d[23:16];
			four = i < 4 ? i[0] : d[24];
			spi_slave_select_mode <= four ? {d[25], 1'b1} : 2'h0;
			wr(12'h048, sk);
			wr(12'h384, r0);
			pl = place(r0, sk, four);
			po = e[27:14];
			pout = e[13:0];
			ein = '0;
			for (int p = 0; p < 8; p++)
			begin
				s = pl[p*4+:4];
				eoe[p] = s == 4'hF ? 1'b1 : s > 7 && s < 10 ? po[s] & ~pout[s] : po[s];
				eout[p] = s == 4'hF ? 1'b1 : s > 7 && s < 10 ? 1'b0 : pout[s];
				if (s != 4'hF)
					ein[s] = eoe[p] ? eout[p] : d[p + 26 - (p > 5 ? 32 : 0)];
			end
			periph_oe <= po;
			periph_out <= pout;
			ext_en <= ~eoe;
			ext_val <= {d[1:0], d[31:26]};
			repeat (3) @(posedge clk);
			chk("pin_oe", eoe, pin_oe);
			chk("pin_out", eout & eoe, pin_out & pin_oe);
			chk("periph_in", ein, periph_in);
		end
		$display("test placement done");
		ext_en <= '1;
		ext_val <= 8'hA5;
		wr(12'h384, 0);
		wr(12'h044, 0);
		chk("pin_oe", 0, pin_oe);
		chk("pullup", 8'hFF, pin_pullup_en);
		wr(12'h04C, 0);
		chk("pin_oe", 8'hFF, pin_oe);
		chk("pullup", 0, pin_pullup_en);
		wr(12'h04C, 32'hFF);
		wr(12'h31C, 32'hC0);
		chk("pullup", 0, pin_pullup_en);
		wr(12'h31C, 32'h40);
		wr(12'h040, 32'hF0);
		wr(12'h048, 32'h0F);
		chk("receiver", 8'hF0, pin_receiver_en);
		chk("pullup", 8'hF0, pin_pullup_en);
		rd(12'h050, d, r);
		chk("pin_state", 8'hA0, d);
		wr(12'h04C, 0);
		chk("pin_oe", 8'hF0, pin_oe);
		wr(12'h31C, 0);
		chk("pin_oe", 0, pin_oe);
		$display("test modes done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
